// ===== pmx_pad_mux.sv
// pad function select mux: register bank, per-pad routing, reset pad states,
// fault and warm-reset open-drain pads, error input and boot sense capture
// assumes pad inputs synchronous to i_clk; the pad ring resolves oe into the wire level
//
// Contract
// R1 - register decodes when address top half is all ones and low half is pad offset
// R2 - bits 3:0 of each register pick the function routed to that pad
// R3 - during power-on reset pads float with their listed weak pull
// R4 - first port chip-select pad: 0 line 30, 1 chip select; pulls up
// R5 - port-2 data-in pad: 0 line 21, 1 data in, 2 two-wire data
// R6 - port-2 data-out pad: 0 line 22, 1 data out, 2 two-wire clock
// R7 - port-2 clock pad: 0 line 5, 1 clock, 6 main trace, 7 radio tx
// R8 - port-2 select pad: 0 line 4, 1 select, 6 main trace, 7 radio tx
// R9 - flash data pads: lines 8-11, lanes, code 2 port-2 data; pull down
// R10 - flash clock pad: 0 line 7, 1 flash clock, 2 port-2 clock
// R11 - flash select pad: 0 line 6, 1 flash select, 2 port-2 select; pull up
// R12 - fault pad is open drain, set on severe fault, cleared only by reset
// R13 - warm-reset pad open drain: external low forces reset, device shows reset
// R14 - external error input goes to the error monitor
// R15 - scan pads: code 1 scan, clock pad 2/6 trace, mode pad 2 radio tx
// R16 - three sense lines sampled at reset release choose boot mode
// R17 - host clock pad: 0 line 25, 1 clock out, 10 radio receive
// R18 - general pad 2: 26, line 2, trace tx, radio tx, sync out, power clock
// R19 - sync-in pad: 0 line 28, 1 sync in, 6 main trace receive
// R20 - power clock pad: 0 line 27, 1 dithered power-manager clock
// R21 - debug receive pad: 15, debug rx, loader rx, radio tx, trace rx
// R22 - debug transmit pad: 14, debug tx, loader tx, trace tx, radio tx
// R23 - unlisted codes are reserved; the pad is left unconnected
`timescale 1ns/1ps
`default_nettype none

module pmx_pad_mux
    import pmx_pkg::*;
(
    input wire logic i_clk,                // 20 MHz system clock
    input wire logic i_sys_rst,            // power-on reset, async, active high
    input wire logic [31:0] i_addr,        // register address
    input wire logic [31:0] i_wdata,       // register write data
    input wire logic i_wr,                 // write strobe
    input wire logic i_rd,                 // read strobe
    output logic [31:0] o_rdata,           // read data, cycle after i_rd
    input wire pmx_core_s i_core,          // function values and enables from core
    output pmx_pad_s o_pad,                // pad outputs and enables
    input wire logic [PMX_NPAD-1:0] i_pad_in, // pad input levels
    output pmx_pull_s o_pull,              // weak pull enables
    output logic [PMX_NFN-1:0] o_fn_in,    // pad levels routed to functions
    input wire logic i_severe_fault,       // severe fault event
    output logic o_fault_n_out,            // fault pad output value
    output logic o_fault_n_oe,             // fault pad drive enable
    input wire logic i_warm_rst_n_in,      // warm-reset pad level
    output logic o_warm_rst_n_out,         // warm-reset pad output value
    output logic o_warm_rst_n_oe,          // warm-reset pad drive enable
    output logic o_warm_rst_req,           // external warm reset request
    input wire logic i_err_in_n,           // external error input pad
    output logic o_err_flag,               // error toward the monitor
    output logic [2:0] o_boot_mode         // boot sense captured at release
);

    typedef struct packed {
        logic in_rst;
        logic [PMX_NPAD-1:0][PMX_SELW-1:0] sel;
        logic [31:0] rdata;
        logic [PMX_NPAD-1:0] pad_out;
        logic [PMX_NPAD-1:0] pad_oe;
        logic [PMX_NFN-1:0] fn_in;
        logic fault;
        logic err;
        logic warm_req;
        logic [2:0] boot;
    } pmx_state_s;

    localparam pmx_state_s ST_RST = '{in_rst: 1'b1, sel: {PMX_NPAD{PMX_SEL_RST}}, default: '0};

    pmx_state_s st;
    pmx_state_s next_st;

    // routing table: pad index and code to function id
    function automatic logic [PMX_FNW-1:0] route(input int pad, input logic [PMX_SELW-1:0] code);
        logic [PMX_FNW-1:0] f;
        f = FN_NONE;
        case (pad)
            PAD_CHIPSEL1: begin
                if (code == 4'h0) f = 6'h1E; // [R4]
                if (code == 4'h1) f = FN_SPI1_CS; // [R4]
            end
            PAD_P2_DIN: begin
                if (code == 4'h0) f = 6'h15; // [R5]
                if (code == 4'h1) f = FN_SPI2_DIN; // [R5]
                if (code == 4'h2) f = FN_TWI_SDA; // [R5]
            end
            PAD_P2_DOUT: begin
                if (code == 4'h0) f = 6'h16; // [R6]
                if (code == 4'h1) f = FN_SPI2_DOUT; // [R6]
                if (code == 4'h2) f = FN_TWI_SCL; // [R6]
            end
            PAD_P2_CLK, PAD_P2_CS: begin
                if (code == 4'h0) f = (pad == PAD_P2_CLK) ? 6'h05 : 6'h04; // [R7] [R8]
                if (code == 4'h1) f = (pad == PAD_P2_CLK) ? FN_SPI2_CLK : FN_SPI2_CS; // [R7] [R8]
                if (code == 4'h6) f = FN_MAIN_TRACE_UART_TX; // [R7] [R8]
                if (code == 4'h7) f = FN_RADIO_TRACE_UART_TX; // [R7] [R8]
            end
            PAD_FLASH_D0, PAD_FLASH_D1, PAD_FLASH_D2, PAD_FLASH_D3: begin
                if (code == 4'h0) f = PMX_FNW'(pad - PAD_FLASH_D0 + 8); // [R9]
                if (code == 4'h1) f = PMX_FNW'(FN_FLASH_D0 + PMX_FNW'(pad - PAD_FLASH_D0)); // [R9]
                if (code == 4'h2 && pad == PAD_FLASH_D0) f = FN_SPI2_DOUT; // [R9]
                if (code == 4'h2 && pad == PAD_FLASH_D1) f = FN_SPI2_DIN; // [R9]
            end
            PAD_FLASH_CLK: begin
                if (code == 4'h0) f = 6'h07; // [R10]
                if (code == 4'h1) f = FN_FLASH_CLK; // [R10]
                if (code == 4'h2) f = FN_SPI2_CLK; // [R10]
            end
            PAD_FLASH_CS: begin
                if (code == 4'h0) f = 6'h06; // [R11]
                if (code == 4'h1) f = FN_FLASH_CS; // [R11]
                if (code == 4'h2) f = FN_SPI2_CS; // [R11]
            end
            PAD_SCAN_CLK: begin
                if (code == 4'h0) f = 6'h11;
                if (code == 4'h1) f = FN_SCAN_CLK; // [R15]
                if (code == 4'h2) f = FN_MAIN_TRACE_UART_TX; // [R15]
                if (code == 4'h6) f = FN_RADIO_TRACE_UART_RX; // [R15]
            end
            PAD_SCAN_MODE: begin
                if (code == 4'h0) f = 6'h12;
                if (code == 4'h1) f = FN_SCAN_MODE; // [R15]
                if (code == 4'h2) f = FN_RADIO_TRACE_UART_TX; // [R15]
            end
            PAD_SCAN_DIN: begin
                if (code == 4'h0) f = 6'h17;
                if (code == 4'h1) f = FN_SCAN_DIN; // [R15]
            end
            PAD_SCAN_DOUT: begin
                // code 7 is the boot sense use: the pad stays an undriven input
                if (code == 4'h0) f = 6'h18;
                if (code == 4'h1) f = FN_SCAN_DOUT; // [R15]
                if (code == 4'h6) f = FN_MAIN_TRACE_UART_TX;
            end
            PAD_HOST_CLK: begin
                if (code == 4'h0) f = 6'h19; // [R17]
                if (code == 4'h1) f = FN_HOST_CLOCK_OUTPUT; // [R17]
                if (code == 4'hA) f = FN_RADIO_TRACE_UART_RX; // [R17]
            end
            PAD_GENERAL2: begin
                if (code == 4'h0) f = 6'h1A; // [R18]
                if (code == 4'h1) f = 6'h02; // [R18]
                if (code == 4'h7) f = FN_MAIN_TRACE_UART_TX; // [R18]
                if (code == 4'h8) f = FN_RADIO_TRACE_UART_TX; // [R18]
                if (code == 4'h9) f = FN_SYNC_OUT; // [R18]
                if (code == 4'hA) f = FN_POWER_MANAGER_CLOCK; // [R18]
            end
            PAD_POWER_CLK: begin
                if (code == 4'h0) f = 6'h1B; // [R20]
                if (code == 4'h1) f = FN_POWER_MANAGER_CLOCK; // [R20]
            end
            PAD_SYNC_IN: begin
                if (code == 4'h0) f = 6'h1C; // [R19]
                if (code == 4'h1) f = FN_SYNC_IN; // [R19]
                if (code == 4'h6) f = FN_MAIN_TRACE_UART_RX; // [R19]
            end
            PAD_SYNC_OUT: begin
                if (code == 4'h0) f = 6'h1D;
                if (code == 4'h1) f = FN_SYNC_OUT;
            end
            PAD_DBG_RX: begin
                if (code == 4'h0) f = 6'h0F; // [R21]
                if (code == 4'h1) f = FN_DEBUG_SERIAL_RECEIVE; // [R21]
                if (code == 4'h2) f = FN_MAIN_LOADER_UART_RX; // [R21]
                if (code == 4'h6) f = FN_RADIO_TRACE_UART_TX; // [R21]
                if (code == 4'h7) f = FN_MAIN_TRACE_UART_RX; // [R21]
            end
            PAD_DBG_TX: begin
                if (code == 4'h0) f = 6'h0E; // [R22]
                if (code == 4'h1) f = FN_DEBUG_SERIAL_TRANSMIT; // [R22]
                if (code == 4'h5) f = FN_MAIN_LOADER_UART_TX; // [R22]
                if (code == 4'h6) f = FN_MAIN_TRACE_UART_TX; // [R22]
                if (code == 4'h7) f = FN_RADIO_TRACE_UART_TX; // [R22]
            end
            default: f = FN_NONE;
        endcase
        return f;
    endfunction

    logic [PMX_NPAD-1:0] hit;
    logic [PMX_NPAD-1:0][PMX_FNW-1:0] fid;

    // per-pad address match and current route
    for (genvar p = 0; p < PMX_NPAD; p++) begin : g_pad
        assign hit[p] = (i_addr[31:16] == PMX_ADDR_HIGH) && (i_addr[15:0] == PMX_PAD_OFS[p]); // [R1]
        assign fid[p] = route(p, st.sel[p]); // [R2]
    end

    always_comb begin
        next_st = st;
        next_st.in_rst = 1'b0;
        next_st.rdata = '0;
        next_st.fn_in = '0;
        for (int p = 0; p < PMX_NPAD; p++) begin
            if (i_wr && hit[p]) begin
                next_st.sel[p] = i_wdata[PMX_SELW-1:0]; // [R1] [R2]
            end
            if (i_rd && hit[p]) begin
                next_st.rdata = {{(32 - PMX_SELW){1'b0}}, st.sel[p]}; // [R2]
            end
            // reserved codes map to no function, so the pad floats [R23]
            if (fid[p] != FN_NONE) begin
                next_st.pad_out[p] = i_core.drive[fid[p]];
                next_st.pad_oe[p] = i_core.enable[fid[p]] && !st.in_rst; // [R3]
                next_st.fn_in[fid[p]] = i_pad_in[p];
            end else begin
                next_st.pad_out[p] = 1'b0;
                next_st.pad_oe[p] = 1'b0;
            end
        end
        // sticky until reset; nothing in software can clear it
        next_st.fault = st.fault || i_severe_fault; // [R12]
        next_st.err = !i_err_in_n; // [R14]
        // own drive of the pad during reset must not read as an external request
        next_st.warm_req = !i_warm_rst_n_in && !st.in_rst; // [R13]
        // sense lines float during reset, so the first edge after release catches them
        if (st.in_rst) begin
            next_st.boot = {i_pad_in[PMX_SENSE2_PAD], i_pad_in[PMX_SENSE1_PAD],
                            i_pad_in[PMX_SENSE0_PAD]}; // [R16]
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= ST_RST; // [R3]
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_pad.out = st.pad_out;
    assign o_pad.oe = st.pad_oe;
    assign o_pull.up = PMX_PULL_UP & {PMX_NPAD{st.in_rst}}; // [R3] [R4] [R9] [R11]
    assign o_pull.down = PMX_PULL_DN & {PMX_NPAD{st.in_rst}}; // [R3] [R9]
    assign o_fn_in = st.fn_in;
    assign o_fault_n_out = 1'b0;
    assign o_fault_n_oe = st.fault; // [R12]
    assign o_warm_rst_n_out = 1'b0;
    assign o_warm_rst_n_oe = st.in_rst; // [R13]
    assign o_warm_rst_req = st.warm_req; // [R13]
    assign o_err_flag = st.err; // [R14]
    assign o_boot_mode = st.boot; // [R16]

    sequence reset_release_s;
        st.in_rst ##1 !st.in_rst;
    endsequence

    sequence write_pad0_s;
        i_wr && (i_addr == {PMX_ADDR_HIGH, PMX_PAD_OFS[PAD_CHIPSEL1]});
    endsequence

    decode_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R1]
        write_pad0_s |=> st.sel[PAD_CHIPSEL1] == $past(i_wdata[PMX_SELW-1:0]))
        else $error("pad select write not decoded");

    read_field_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R2]
        i_rd && hit[PAD_P2_CLK] |=> o_rdata == {28'h0, $past(st.sel[PAD_P2_CLK])})
        else $error("pad select read wrong");

    reset_float_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R3]
        st.in_rst |-> (o_pad.oe == '0) && (o_pull.up == PMX_PULL_UP))
        else $error("pad driven or pull missing in reset");

    sda_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R5]
        st.sel[PAD_P2_DIN] == 4'h2 && !st.in_rst
        |=> o_pad.out[PAD_P2_DIN] == $past(i_core.drive[FN_TWI_SDA]))
        else $error("two-wire data not routed");

    radio_tx_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
        st.sel[PAD_P2_CLK] == 4'h7 && !st.in_rst
        |=> o_pad.oe[PAD_P2_CLK] == $past(i_core.enable[FN_RADIO_TRACE_UART_TX]))
        else $error("radio transmit not routed");

    fault_sticky_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
        i_severe_fault |=> o_fault_n_oe [*8])
        else $error("fault pad released before reset");

    warm_show_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R13]
        reset_release_s |-> !o_warm_rst_n_oe && $past(o_warm_rst_n_oe))
        else $error("warm reset pad not tracking reset");

    err_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
        !i_err_in_n |=> o_err_flag)
        else $error("error input not passed on");

    boot_sense_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R16]
        reset_release_s |-> o_boot_mode == {$past(i_pad_in[PMX_SENSE2_PAD]),
            $past(i_pad_in[PMX_SENSE1_PAD]), $past(i_pad_in[PMX_SENSE0_PAD])})
        else $error("boot sense not captured");

    reserved_float_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R23]
        st.sel[PAD_FLASH_D2] == 4'h5 |=> !o_pad.oe[PAD_FLASH_D2])
        else $error("reserved code drives a pad");

endmodule // pmx_pad_mux

`default_nettype wire

// ===== pmx_pkg.sv
// package for the pad function select mux: pad map, pulls, function ids, carrier structs
// assumes one system clock and a plain address/strobe register port
package pmx_pkg;

    localparam int PMX_NPAD = 22;
    localparam int PMX_NFN = 64;
    localparam int PMX_FNW = 6;
    localparam int PMX_SELW = 4;

    // register decode
    localparam logic [15:0] PMX_ADDR_HIGH = 16'hFFFF;
    localparam logic [15:0] PMX_PAD_OFS [PMX_NPAD] = '{
        16'hEA18, 16'hEA1C, 16'hEA20, 16'hEA24, 16'hEA28, 16'hEA2C,
        16'hEA30, 16'hEA34, 16'hEA38, 16'hEA3C, 16'hEA40, 16'hEA50,
        16'hEA54, 16'hEA58, 16'hEA5C, 16'hEA60, 16'hEA64, 16'hEA68,
        16'hEA6C, 16'hEA70, 16'hEA74, 16'hEA78
    };
    localparam logic [PMX_SELW-1:0] PMX_SEL_RST = 4'h0;

    // pad indices
    localparam int PAD_CHIPSEL1 = 0;
    localparam int PAD_P2_DIN = 1;
    localparam int PAD_P2_DOUT = 2;
    localparam int PAD_P2_CLK = 3;
    localparam int PAD_P2_CS = 4;
    localparam int PAD_FLASH_D0 = 5;
    localparam int PAD_FLASH_D1 = 6;
    localparam int PAD_FLASH_D2 = 7;
    localparam int PAD_FLASH_D3 = 8;
    localparam int PAD_FLASH_CLK = 9;
    localparam int PAD_FLASH_CS = 10;
    localparam int PAD_SCAN_CLK = 11;
    localparam int PAD_SCAN_MODE = 12;
    localparam int PAD_SCAN_DIN = 13;
    localparam int PAD_SCAN_DOUT = 14;
    localparam int PAD_HOST_CLK = 15;
    localparam int PAD_GENERAL2 = 16;
    localparam int PAD_POWER_CLK = 17;
    localparam int PAD_SYNC_IN = 18;
    localparam int PAD_SYNC_OUT = 19;
    localparam int PAD_DBG_RX = 20;
    localparam int PAD_DBG_TX = 21;

    // weak pulls while in power-on reset
    localparam logic [PMX_NPAD-1:0] PMX_PULL_UP = 22'h103401;
    localparam logic [PMX_NPAD-1:0] PMX_PULL_DN = 22'h0F8BE0;

    // boot sense pads
    localparam int PMX_SENSE0_PAD = PAD_SCAN_DOUT;
    localparam int PMX_SENSE1_PAD = PAD_SYNC_OUT;
    localparam int PMX_SENSE2_PAD = PAD_POWER_CLK;

    // function ids: 0..31 are general-purpose lines, 32..60 are peripherals, 63 is no function
    localparam logic [PMX_FNW-1:0] FN_SPI1_CS = 6'h20;
    localparam logic [PMX_FNW-1:0] FN_SPI2_DIN = 6'h21;
    localparam logic [PMX_FNW-1:0] FN_SPI2_DOUT = 6'h22;
    localparam logic [PMX_FNW-1:0] FN_SPI2_CLK = 6'h23;
    localparam logic [PMX_FNW-1:0] FN_SPI2_CS = 6'h24;
    localparam logic [PMX_FNW-1:0] FN_TWI_SDA = 6'h25;
    localparam logic [PMX_FNW-1:0] FN_TWI_SCL = 6'h26;
    localparam logic [PMX_FNW-1:0] FN_MAIN_TRACE_UART_TX = 6'h27;
    localparam logic [PMX_FNW-1:0] FN_RADIO_TRACE_UART_TX = 6'h28;
    localparam logic [PMX_FNW-1:0] FN_RADIO_TRACE_UART_RX = 6'h29;
    localparam logic [PMX_FNW-1:0] FN_MAIN_TRACE_UART_RX = 6'h2A;
    localparam logic [PMX_FNW-1:0] FN_FLASH_D0 = 6'h2B;
    localparam logic [PMX_FNW-1:0] FN_FLASH_D1 = 6'h2C;
    localparam logic [PMX_FNW-1:0] FN_FLASH_D2 = 6'h2D;
    localparam logic [PMX_FNW-1:0] FN_FLASH_D3 = 6'h2E;
    localparam logic [PMX_FNW-1:0] FN_FLASH_CLK = 6'h2F;
    localparam logic [PMX_FNW-1:0] FN_FLASH_CS = 6'h30;
    localparam logic [PMX_FNW-1:0] FN_SCAN_CLK = 6'h31;
    localparam logic [PMX_FNW-1:0] FN_SCAN_MODE = 6'h32;
    localparam logic [PMX_FNW-1:0] FN_SCAN_DIN = 6'h33;
    localparam logic [PMX_FNW-1:0] FN_SCAN_DOUT = 6'h34;
    localparam logic [PMX_FNW-1:0] FN_HOST_CLOCK_OUTPUT = 6'h35;
    localparam logic [PMX_FNW-1:0] FN_SYNC_OUT = 6'h36;
    localparam logic [PMX_FNW-1:0] FN_POWER_MANAGER_CLOCK = 6'h37;
    localparam logic [PMX_FNW-1:0] FN_SYNC_IN = 6'h38;
    localparam logic [PMX_FNW-1:0] FN_DEBUG_SERIAL_RECEIVE = 6'h39;
    localparam logic [PMX_FNW-1:0] FN_DEBUG_SERIAL_TRANSMIT = 6'h3A;
    localparam logic [PMX_FNW-1:0] FN_MAIN_LOADER_UART_RX = 6'h3B;
    localparam logic [PMX_FNW-1:0] FN_MAIN_LOADER_UART_TX = 6'h3C;
    localparam logic [PMX_FNW-1:0] FN_NONE = 6'h3F;

    // core side of every function: value and enable toward the pad
    typedef struct packed {
        logic [PMX_NFN-1:0] drive;
        logic [PMX_NFN-1:0] enable;
    } pmx_core_s;

    // pad side: output value and output enable per pad
    typedef struct packed {
        logic [PMX_NPAD-1:0] out;
        logic [PMX_NPAD-1:0] oe;
    } pmx_pad_s;

    typedef struct packed {
        logic [PMX_NPAD-1:0] up;
        logic [PMX_NPAD-1:0] down;
    } pmx_pull_s;

endpackage

// ===== tb_pmx_pad_mux.sv
// testbench for the pad function select mux: register port, routing table,
// reset pad states, fault, error input, warm reset and boot sense capture
// assumes pmx_pkg and pmx_pad_mux are compiled first; one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb_pmx_pad_mux
    import pmx_pkg::*;
;
    logic i_clk = 1'h0;
    logic i_sys_rst = 1'h1;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'h0;
    logic i_rd = 1'h0;
    logic [31:0] o_rdata;
    pmx_core_s i_core = '0;
    pmx_pad_s o_pad;
    logic [PMX_NPAD-1:0] i_pad_in = '0;
    pmx_pull_s o_pull;
    logic [PMX_NFN-1:0] o_fn_in;
    logic i_severe_fault = 1'h0;
    logic o_fault_n_out, o_fault_n_oe;
    logic i_warm_rst_n_in = 1'h1;
    logic o_warm_rst_n_out, o_warm_rst_n_oe, o_warm_rst_req;
    logic i_err_in_n = 1'h1;
    logic o_err_flag;
    logic [2:0] o_boot_mode;
    logic [31:0] rdv;
    int bad_count = 0;
    int checks = 0;

    pmx_pad_mux i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core(i_core),
        .o_pad(o_pad), .i_pad_in(i_pad_in), .o_pull(o_pull), .o_fn_in(o_fn_in),
        .i_severe_fault(i_severe_fault), .o_fault_n_out(o_fault_n_out),
        .o_fault_n_oe(o_fault_n_oe), .i_warm_rst_n_in(i_warm_rst_n_in),
        .o_warm_rst_n_out(o_warm_rst_n_out), .o_warm_rst_n_oe(o_warm_rst_n_oe),
        .o_warm_rst_req(o_warm_rst_req), .i_err_in_n(i_err_in_n), .o_err_flag(o_err_flag),
        .o_boot_mode(o_boot_mode));

    always #25 i_clk = ~i_clk;

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("counts: %0d compares, %0d mismatches", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask

    // read data is only valid in the cycle right after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1;
        d = o_rdata;
    endtask

    // pulls expected from the listed weak pull per pad, not from the package
    task automatic do_reset(input logic [PMX_NPAD-1:0] pins, input logic [2:0] boot);
        @(posedge i_clk);
        i_sys_rst <= 1'h1;
        i_pad_in <= pins;
        repeat (6) @(posedge i_clk);
        #1;
        cmp(32'(o_pull.up), 32'h103401);
        cmp(32'(o_pull.down), 32'h0F8BE0);
        cmp(32'(o_pad.oe), 32'h0);
        cmp(32'({o_warm_rst_n_oe, o_warm_rst_n_out, o_fault_n_oe}), 32'h4);
        @(posedge i_clk);
        i_sys_rst <= 1'h0;
        repeat (3) @(posedge i_clk);
        #1;
        cmp(32'(o_boot_mode), 32'(boot));
        cmp(32'({o_pull.up, o_pull.down, o_warm_rst_n_oe}), 32'h0);
        $display("test reset done");
    endtask

    // k: 0 output route, 1 input route, 2 reserved code leaves pad unconnected
    task automatic route(input int p, input int c, input int f, input int k);
        pmx_core_s cv;
        logic [31:0] a;
        a = {PMX_ADDR_HIGH, PMX_PAD_OFS[p]};
        cv.drive = (k == 2) ? '1 : (64'h1 << f);
        cv.enable = (k == 2) ? '1 : (64'h1 << f);
        @(posedge i_clk);
        i_core <= cv;
        i_pad_in <= 22'h1 << p;
        wr(a, 32'(c));
        repeat (2) @(posedge i_clk);
        #1;
        if (k == 0) begin
            cmp(32'({o_pad.out[p], o_pad.oe[p]}), 32'h3);
        end else if (k == 1) begin
            cmp(32'(o_fn_in[f]), 32'h1);
        end else begin
            // fold the function inputs so the pad bits are not cut by the 32-bit compare
            cmp(32'({o_pad.out[p], o_pad.oe[p], |o_fn_in}), 32'h0);
        end
        rd(a, rdv);
        cmp(rdv, 32'(c));
        wr(a, 32'h0);
    endtask

    initial begin
        #1000000;
        bad_count++;
        finish_test();
    end

    initial begin
        do_reset(22'h024000, 3'h5);
        wr(32'hFFFFEA18, 32'hFFFFFFF6);
        rd(32'hFFFFEA18, rdv);
        cmp(rdv, 32'h6);
        @(posedge i_clk);
        #1;
        cmp(o_rdata, 32'h0);
        wr(32'h0000EA18, 32'h3);
        rd(32'hFFFFEA18, rdv);
        cmp(rdv, 32'h6);
        rd(32'h0000EA18, rdv);
        cmp(rdv, 32'h0);
        rd(32'hFFFFEA44, rdv);
        cmp(rdv, 32'h0);
        wr(32'hFFFFEA18, 32'h0);
        $display("test register port done");
        route(0, 0, 30, 0); route(0, 0, 30, 1); route(0, 1, FN_SPI1_CS, 0);
        route(1, 0, 21, 0); route(1, 1, FN_SPI2_DIN, 1); route(1, 2, FN_TWI_SDA, 0);
        route(2, 0, 22, 0); route(2, 1, FN_SPI2_DOUT, 0); route(2, 2, FN_TWI_SCL, 0);
        route(3, 0, 5, 0); route(3, 1, FN_SPI2_CLK, 0);
        route(3, 6, FN_MAIN_TRACE_UART_TX, 0); route(3, 7, FN_RADIO_TRACE_UART_TX, 0);
        route(4, 0, 4, 0); route(4, 1, FN_SPI2_CS, 0);
        route(4, 6, FN_MAIN_TRACE_UART_TX, 0); route(4, 7, FN_RADIO_TRACE_UART_TX, 0);
        route(5, 0, 8, 0); route(5, 1, FN_FLASH_D0, 0); route(5, 2, FN_SPI2_DOUT, 0);
        route(6, 2, FN_SPI2_DIN, 1); route(7, 1, FN_FLASH_D2, 0); route(8, 0, 11, 0);
        route(9, 0, 7, 0); route(9, 1, FN_FLASH_CLK, 0); route(9, 2, FN_SPI2_CLK, 0);
        route(10, 0, 6, 0); route(10, 1, FN_FLASH_CS, 0); route(10, 2, FN_SPI2_CS, 0);
        route(11, 1, FN_SCAN_CLK, 1); route(11, 2, FN_MAIN_TRACE_UART_TX, 0);
        route(11, 6, FN_RADIO_TRACE_UART_RX, 1); route(12, 2, FN_RADIO_TRACE_UART_TX, 0);
        route(15, 0, 25, 0); route(15, 1, FN_HOST_CLOCK_OUTPUT, 0);
        route(15, 10, FN_RADIO_TRACE_UART_RX, 1);
        route(16, 0, 26, 0); route(16, 1, 2, 0); route(16, 7, FN_MAIN_TRACE_UART_TX, 0);
        route(16, 8, FN_RADIO_TRACE_UART_TX, 0); route(16, 9, FN_SYNC_OUT, 0);
        route(16, 10, FN_POWER_MANAGER_CLOCK, 0);
        route(18, 0, 28, 1); route(18, 1, FN_SYNC_IN, 1); route(18, 6, FN_MAIN_TRACE_UART_RX, 1);
        route(17, 0, 27, 0); route(17, 1, FN_POWER_MANAGER_CLOCK, 0);
        route(20, 0, 15, 0); route(20, 1, FN_DEBUG_SERIAL_RECEIVE, 1);
        route(20, 2, FN_MAIN_LOADER_UART_RX, 1); route(20, 6, FN_RADIO_TRACE_UART_TX, 0);
        route(20, 7, FN_MAIN_TRACE_UART_RX, 1); route(21, 0, 14, 0);
        route(21, 1, FN_DEBUG_SERIAL_TRANSMIT, 0); route(21, 5, FN_MAIN_LOADER_UART_TX, 0);
        route(21, 6, FN_MAIN_TRACE_UART_TX, 0); route(21, 7, FN_RADIO_TRACE_UART_TX, 0);
        route(0, 5, FN_NONE, 2); route(16, 15, FN_NONE, 2); route(19, 4, FN_NONE, 2);
        route(7, 5, FN_NONE, 2);
        $display("test routing done");
        @(posedge i_clk);
        i_err_in_n <= 1'h0;
        i_warm_rst_n_in <= 1'h0;
        repeat (2) @(posedge i_clk);
        #1;
        cmp(32'({o_err_flag, o_warm_rst_req}), 32'h3);
        @(posedge i_clk);
        i_err_in_n <= 1'h1;
        i_warm_rst_n_in <= 1'h1;
        repeat (2) @(posedge i_clk);
        #1;
        cmp(32'({o_err_flag, o_warm_rst_req}), 32'h0);
        $display("test error and warm reset done");
        @(posedge i_clk);
        i_severe_fault <= 1'h1;
        @(posedge i_clk);
        i_severe_fault <= 1'h0;
        repeat (20) @(posedge i_clk);
        #1;
        cmp(32'({o_fault_n_oe, o_fault_n_out}), 32'h2);
        do_reset(22'h080000, 3'h2);
        cmp(32'(o_fault_n_oe), 32'h0);
        $display("test fault done");
        finish_test();
    end
endmodule // tb_pmx_pad_mux

`default_nettype wire
